/* design/power_control_pkg.sv */
/*
  constants, register layout and state codes for the power control register.
  assumes an apb slave with 32-bit data and one clock domain.
*/
package power_control_pkg;

  // printed offset is a register index; the byte address is four times it
  localparam logic [7:0]  POWER_CONTROL_INDEX = 8'h87;
  localparam logic [11:0] POWER_CONTROL_ADDR  = 12'h21c;
  localparam logic [7:0]  POWER_CONTROL_RESET = 8'h00;

  localparam logic [1:0] PMOD_NORMAL     = 2'h0;
  localparam logic [1:0] PMOD_IDLE       = 2'h1;
  localparam logic [1:0] PMOD_POWER_DOWN = 2'h2;
  localparam logic [1:0] PMOD_TOTAL_DOWN = 2'h3;

  localparam int unsigned WAKE_XTAL_CLOCKS = 1024;
  localparam int unsigned WAKE_RC_CLOCKS   = 256;
  localparam int unsigned WAKE_CNT_W       = 11;

  typedef struct packed {
    logic       uart_rate_double;
    logic       framing_error_select;
    logic       brownout_power_down;
    logic       brownout_response_select;
    logic       user_flag_one;
    logic       user_flag_zero;
    logic [1:0] power_reduction_field;
  } power_control_t;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_IDLE  = 4'b0010,
    ST_PDOWN = 4'b0100,
    ST_WAKE  = 4'b1000
  } power_state_t;

endpackage

/* design/power_control_register.sv */
/*
  power control register with apb access, uart rate and serial bit 7
  routing, brownout control, flash command gating and power mode sequencing.
  assumes timer, serial, flash and wake inputs are on sys_clk_in; only
  brownout_detect_in and rst_n_in come from outside and are synchronised.
*/
`timescale 1ns/1ps
module power_control_register #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              timer1_overflow_in,
  output logic                   uart_rate_tick_out,
  input  wire logic              serial_bit7_write_in,
  input  wire logic              serial_bit7_wdata_in,
  input  wire logic              framing_error_set_in,
  output logic                   serial_bit7_rdata_out,
  output logic                   serial_mode_bit_low_out,
  output logic                   framing_error_flag_out,
  input  wire logic              brownout_detect_in,
  output logic                   brownout_detect_enable_out,
  output logic                   brownout_irq_out,
  output logic                   brownout_reset_out,
  input  wire logic              flash_cmd_in,
  output logic                   flash_cmd_accept_out,
  output logic                   flash_cmd_abort_out,
  input  wire logic              wake_irq_in,
  input  wire logic              osc_is_crystal_in,
  output logic                   cpu_run_out,
  output logic                   idle_out,
  output logic                   osc_enable_out
);

  // register byte address needs ten bits
  if (ADDR_W < 10) begin : g_addr_w_check
    $error("ADDR_W too small for the register address");
  end

  localparam int unsigned WAKE_CNT_W_L = power_control_pkg::WAKE_CNT_W;
  localparam logic [WAKE_CNT_W_L-1:0] XTAL_LOAD =
    WAKE_CNT_W_L'(power_control_pkg::WAKE_XTAL_CLOCKS - 1);
  localparam logic [WAKE_CNT_W_L-1:0] RC_LOAD =
    WAKE_CNT_W_L'(power_control_pkg::WAKE_RC_CLOCKS - 1);

  logic                              rst_meta_q;
  logic                              rst_n;
  power_control_pkg::power_control_t power_control_q;
  power_control_pkg::power_state_t   state_q;
  logic [WAKE_CNT_W_L-1:0]           wake_cnt_q;
  logic                              half_q;
  logic                              bo_meta_q;
  logic                              bo_sync_q;
  logic                              bo_prev_q;
  logic                              bo_event;
  logic                              addr_hit;
  logic                              reg_write;
  logic                              pmod_clear;
  logic [31:0]                       prdata_q;
  logic                              sm0_q;
  logic                              fe_q;
  logic                              tick_q;
  logic                              bo_irq_q;
  logic                              bo_rst_q;
  logic                              accept_q;
  logic                              abort_q;

  // reset released through two flops so release is glitch free
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // apb: zero wait states, unmapped address answers with an error
  assign addr_hit    = (paddr_in ==
                        ADDR_W'(power_control_pkg::POWER_CONTROL_ADDR));
  assign reg_write   = psel_in & penable_in & pwrite_in & addr_hit &
                       pstrb_in[0];
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_hit;
  assign prdata_out  = prdata_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_in & ~penable_in) begin
      prdata_q <= addr_hit ? {24'h00_0000, power_control_q} : 32'h0000_0000;
    end
  end

  // hardware clear of the mode field wins over a same-cycle write
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      power_control_q <= power_control_pkg::POWER_CONTROL_RESET;
    end else begin
      if (reg_write) begin
        power_control_q <= pwdata_in[7:0];
      end
      if (pmod_clear) begin
        power_control_q.power_reduction_field <= power_control_pkg::PMOD_NORMAL;
      end
    end
  end

  // the registered tick costs one cycle of latency on every passed tick, at both rates
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      if (timer1_overflow_in) begin
        half_q <= ~half_q;
      end
      tick_q <= timer1_overflow_in &
                (power_control_q.uart_rate_double | half_q);
    end
  end
  assign uart_rate_tick_out = tick_q;

  // framing error set wins over a software clear
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sm0_q <= 1'b0;
      fe_q  <= 1'b0;
    end else begin
      if (serial_bit7_write_in & ~power_control_q.framing_error_select) begin
        sm0_q <= serial_bit7_wdata_in;
      end
      if (framing_error_set_in) begin
        fe_q <= 1'b1;
      end else if (serial_bit7_write_in & power_control_q.framing_error_select) begin
        fe_q <= serial_bit7_wdata_in;
      end
    end
  end
  assign serial_mode_bit_low_out = sm0_q;
  assign framing_error_flag_out  = fe_q;
  assign serial_bit7_rdata_out   = power_control_q.framing_error_select ? fe_q
                                                               : sm0_q;

  // detector also off in total power down
  assign brownout_detect_enable_out = ~power_control_q.brownout_power_down &
    ~((state_q == power_control_pkg::ST_PDOWN) &
      (power_control_q.power_reduction_field ==
       power_control_pkg::PMOD_TOTAL_DOWN));

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bo_meta_q <= 1'b0;
      bo_sync_q <= 1'b0;
      bo_prev_q <= 1'b0;
    end else begin
      bo_meta_q <= brownout_detect_in;
      bo_sync_q <= bo_meta_q;
      bo_prev_q <= bo_sync_q;
    end
  end
  assign bo_event = bo_sync_q & ~bo_prev_q & brownout_detect_enable_out;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bo_irq_q <= 1'b0;
      bo_rst_q <= 1'b0;
    end else begin
      bo_irq_q <= bo_event & power_control_q.brownout_response_select;
      bo_rst_q <= bo_event & ~power_control_q.brownout_response_select;
    end
  end
  assign brownout_irq_out   = bo_irq_q;
  assign brownout_reset_out = bo_rst_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
      abort_q  <= 1'b0;
    end else begin
      accept_q <= flash_cmd_in & ~power_control_q.brownout_power_down;
      abort_q  <= flash_cmd_in & power_control_q.brownout_power_down;
    end
  end
  assign flash_cmd_accept_out = accept_q;
  assign flash_cmd_abort_out  = abort_q;

  assign pmod_clear =
    ((state_q == power_control_pkg::ST_IDLE) & wake_irq_in) |
    ((state_q == power_control_pkg::ST_WAKE) &
     (wake_cnt_q == '0));

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= power_control_pkg::ST_RUN;
      wake_cnt_q <= '0;
    end else begin
      case (state_q)
        power_control_pkg::ST_RUN: begin
          if (power_control_q.power_reduction_field ==
              power_control_pkg::PMOD_IDLE) begin
            state_q <= power_control_pkg::ST_IDLE;
          end else if (power_control_q.power_reduction_field[1]) begin
            state_q <= power_control_pkg::ST_PDOWN;
          end
        end
        power_control_pkg::ST_IDLE: begin
          if (wake_irq_in) begin
            state_q <= power_control_pkg::ST_RUN;
          end
        end
        power_control_pkg::ST_PDOWN: begin
          if (wake_irq_in) begin
            state_q    <= power_control_pkg::ST_WAKE;
            wake_cnt_q <= osc_is_crystal_in ? XTAL_LOAD : RC_LOAD;
          end
        end
        power_control_pkg::ST_WAKE: begin
          if (wake_cnt_q == '0) begin
            state_q <= power_control_pkg::ST_RUN;
          end else begin
            wake_cnt_q <= wake_cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= power_control_pkg::ST_RUN;
        end
      endcase
    end
  end

  // peripherals keep their clock in idle; only the cpu stalls
  assign cpu_run_out    = (state_q == power_control_pkg::ST_RUN);
  assign idle_out       = (state_q == power_control_pkg::ST_IDLE);
  assign osc_enable_out = (state_q != power_control_pkg::ST_PDOWN);

  property p_rate_full;
    @(posedge sys_clk_in) disable iff (!rst_n)
    timer1_overflow_in & power_control_q.uart_rate_double |=> uart_rate_tick_out;
  endproperty
  a_rate_full: assert property (p_rate_full)
    else $error("overflow not passed at double rate");

  property p_rate_half;
    @(posedge sys_clk_in) disable iff (!rst_n)
    timer1_overflow_in & ~power_control_q.uart_rate_double & ~half_q
      |=> ~uart_rate_tick_out;
  endproperty
  a_rate_half: assert property (p_rate_half)
    else $error("overflow not halved");

  property p_mode_bit;
    @(posedge sys_clk_in) disable iff (!rst_n)
    serial_bit7_write_in & ~power_control_q.framing_error_select
      |=> serial_mode_bit_low_out == $past(serial_bit7_wdata_in);
  endproperty
  a_mode_bit: assert property (p_mode_bit)
    else $error("bit 7 write missed the mode bit");

  property p_fe_route;
    @(posedge sys_clk_in) disable iff (!rst_n)
    serial_bit7_write_in & power_control_q.framing_error_select &
      ~framing_error_set_in
      |=> framing_error_flag_out == $past(serial_bit7_wdata_in) &&
          $stable(serial_mode_bit_low_out);
  endproperty
  a_fe_route: assert property (p_fe_route)
    else $error("bit 7 write missed the framing flag");

  property p_bo_off;
    @(posedge sys_clk_in) disable iff (!rst_n)
    power_control_q.brownout_power_down ##1 power_control_q.brownout_power_down
      |-> ~brownout_irq_out & ~brownout_reset_out;
  endproperty
  a_bo_off: assert property (p_bo_off)
    else $error("brownout response while detector off");

  property p_flash;
    @(posedge sys_clk_in) disable iff (!rst_n)
    flash_cmd_in |=> (flash_cmd_abort_out == $past(power_control_q.brownout_power_down))
                     && (flash_cmd_accept_out != flash_cmd_abort_out);
  endproperty
  a_flash: assert property (p_flash)
    else $error("flash command gating wrong");

  sequence s_bo_event;
    bo_event;
  endsequence

  property p_bo_resp;
    @(posedge sys_clk_in) disable iff (!rst_n)
    s_bo_event |=> (brownout_irq_out ==
                    $past(power_control_q.brownout_response_select)) &&
                   (brownout_reset_out != brownout_irq_out);
  endproperty
  a_bo_resp: assert property (p_bo_resp)
    else $error("brownout response kind wrong");

  property p_idle_exit;
    @(posedge sys_clk_in) disable iff (!rst_n)
    idle_out & wake_irq_in |=> cpu_run_out &&
      power_control_q.power_reduction_field == power_control_pkg::PMOD_NORMAL;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle not ended by interrupt");

  sequence s_rc_wake;
    (state_q == power_control_pkg::ST_PDOWN) & wake_irq_in &
      ~osc_is_crystal_in;
  endsequence

  property p_rc_wake;
    @(posedge sys_clk_in) disable iff (!rst_n)
    s_rc_wake |=> osc_enable_out & ~cpu_run_out ##255 ~cpu_run_out
                  ##1 cpu_run_out;
  endproperty
  a_rc_wake: assert property (p_rc_wake)
    else $error("rc wake wait not 256 clocks");

  property p_reset_val;
    @(posedge sys_clk_in)
    !rst_n |-> power_control_q == power_control_pkg::POWER_CONTROL_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("register not cleared by reset");

endmodule

/* dv/power_control_register_tb_top.sv */
/*
  self-checking bench for the power control register: apb access, rate
  ticks, serial bit 7 routing, flash gating, brownout and power modes.
  assumes a single 40 mhz clock and the zero-wait apb slave of the design.
*/
`timescale 1ns/1ps
module power_control_register_tb_top;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel  = 1'b0;
  logic        pen   = 1'b0;
  logic        pwr   = 1'b0;
  logic [11:0] padr  = 12'h000;
  logic [31:0] pwd   = 32'h0;
  logic [3:0]  pst   = 4'h0;
  logic        ovf   = 1'b0;
  logic        b7w   = 1'b0;
  logic        b7d   = 1'b0;
  logic        fes   = 1'b0;
  logic        bod   = 1'b0;
  logic        fc    = 1'b0;
  logic        wk    = 1'b0;
  logic        xtal  = 1'b0;
  logic [31:0] prd;
  logic        prdy, perr, tick, b7r, smb, fef, boen, boirq, borst;
  logic        facc, fab, run, idl, osc;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cyc = 0;
  int          n_tick = 0;
  int          n_irq = 0;
  int          n_rst = 0;
  int          n_acc = 0;
  int          n_ab = 0;
  int          a, b, k;
  // rows: write data, strobes, expected readback, expected detect enable
  logic [7:0]  tw [5] = '{8'h0c, 8'hff, 8'h20, 8'hd0, 8'hfc};
  logic [3:0]  ts [5] = '{4'hf, 4'he, 4'hf, 4'hf, 4'hf};
  logic [7:0]  te [5] = '{8'h0c, 8'h0c, 8'h20, 8'hd0, 8'hfc};
  logic        tn [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  power_control_register u_power_control_register (
    .sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .pstrb_in(pst),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .timer1_overflow_in(ovf), .uart_rate_tick_out(tick),
    .serial_bit7_write_in(b7w), .serial_bit7_wdata_in(b7d),
    .framing_error_set_in(fes), .serial_bit7_rdata_out(b7r),
    .serial_mode_bit_low_out(smb), .framing_error_flag_out(fef),
    .brownout_detect_in(bod), .brownout_detect_enable_out(boen),
    .brownout_irq_out(boirq), .brownout_reset_out(borst),
    .flash_cmd_in(fc), .flash_cmd_accept_out(facc),
    .flash_cmd_abort_out(fab), .wake_irq_in(wk), .osc_is_crystal_in(xtal),
    .cpu_run_out(run), .idle_out(idl), .osc_enable_out(osc));

  always #12.5 clk = ~clk;

  // pulse counters; the ceiling is well above the roughly 1500 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_tick <= n_tick + (tick === 1'b1);
    n_irq <= n_irq + (boirq === 1'b1);
    n_rst <= n_rst + (borst === 1'b1);
    n_acc <= n_acc + (facc === 1'b1);
    n_ab <= n_ab + (fab === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] ad, input logic [7:0] d,
           input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= ad;
    pwd <= {24'h0, d};
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task wr(input logic [7:0] d);
    apb(1'b1, power_control_pkg::POWER_CONTROL_ADDR, d, 4'hf);
  endtask

  task rdchk(input string nm, input logic [7:0] e);
    apb(1'b0, power_control_pkg::POWER_CONTROL_ADDR, 8'h00, 4'h0);
    chk(nm, {24'h0, e}, rd);
  endtask

  task ovf4();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask

  task b7(input logic d);
    @(posedge clk);
    b7w <= 1'b1;
    b7d <= d;
    @(posedge clk);
    b7w <= 1'b0;
    @(negedge clk);
  endtask

  task fl();
    @(posedge clk);
    fc <= 1'b1;
    @(posedge clk);
    fc <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // detector pin held long enough to pass the two-flop synchroniser
  task bo();
    @(posedge clk);
    bod <= 1'b1;
    repeat (8) @(posedge clk);
    bod <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task pd_wake(input logic x, input logic [7:0] m, input int n);
    @(posedge clk);
    xtal <= x;
    wr(m);
    // state follows the stored mode one edge after the write lands
    repeat (2) @(negedge clk);
    chk("osc in power down", 1'b0, osc);
    @(posedge clk);
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    @(negedge clk);
    chk("osc restart", 1'b1, osc);
    k = 0;
    while (run !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk("wake cycles", n, k);
    rdchk("mode after wake", 8'h00);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("reset value", 8'h00);
    chk("run after reset", 1'b1, run);
    chk("pready after reset", 1'b1, prdy);
    chk("detect after reset", 1'b1, boen);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, power_control_pkg::POWER_CONTROL_ADDR, tw[i], ts[i]);
      rdchk("readback", te[i]);
      @(negedge clk);
      chk("detect enable", tn[i], boen);
    end
    $display("test table done");
    apb(1'b0, 12'h220, 8'h00, 4'h0);
    chk("miss error", 32'h1, {31'h0, er});
    chk("miss data", 32'h0, rd);
    apb(1'b1, 12'h220, 8'h00, 4'hf);
    rdchk("miss write ignored", 8'hfc);
    $display("test unmapped done");
    wr(8'h80);
    a = n_tick;
    ovf4();
    chk("double ticks", a + 4, n_tick);
    wr(8'h00);
    a = n_tick;
    ovf4();
    chk("halved ticks", a + 2, n_tick);
    $display("test rate done");
    b7(1'b1);
    chk("mode bit", 1'b1, smb);
    chk("bit7 mode", 1'b1, b7r);
    @(posedge clk);
    fes <= 1'b1;
    @(posedge clk);
    fes <= 1'b0;
    @(negedge clk);
    chk("fe set", 1'b1, fef);
    b7(1'b0);
    chk("mode bit cleared", 1'b0, smb);
    chk("fe kept", 1'b1, fef);
    b7(1'b1);
    chk("mode bit set again", 1'b1, smb);
    wr(8'h40);
    @(negedge clk);
    chk("bit7 fe", 1'b1, b7r);
    b7(1'b0);
    chk("fe cleared", 1'b0, fef);
    chk("mode untouched", 1'b1, smb);
    @(posedge clk);
    fes <= 1'b1;
    b7w <= 1'b1;
    b7d <= 1'b0;
    @(posedge clk);
    fes <= 1'b0;
    b7w <= 1'b0;
    @(negedge clk);
    chk("fe set beats clear", 1'b1, fef);
    $display("test serial done");
    wr(8'h20);
    a = n_ab;
    b = n_acc;
    fl();
    chk("abort", a + 1, n_ab);
    chk("no accept", b, n_acc);
    wr(8'h00);
    fl();
    chk("accept", b + 1, n_acc);
    $display("test flash done");
    wr(8'h10);
    a = n_irq;
    b = n_rst;
    bo();
    chk("bo irq", a + 1, n_irq);
    wr(8'h30);
    bo();
    chk("bo off irq", a + 1, n_irq);
    chk("bo off reset", b, n_rst);
    wr(8'h01);
    repeat (2) @(negedge clk);
    chk("idle", 1'b1, idl);
    chk("cpu halted", 1'b0, run);
    @(posedge clk);
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    @(negedge clk);
    chk("idle wake", 1'b1, run);
    rdchk("idle mode cleared", 8'h00);
    pd_wake(1'b0, 8'h02, 256);
    pd_wake(1'b1, 8'h03, 1024);
    $display("test power done");
    bo();
    chk("bo reset", b + 1, n_rst);
    wr(8'hfc);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk("second reset", 8'h00);
    $display("test brownout and reset done");
    tally_and_finish();
  end
endmodule
